// File: hdl/csp_pkg.sv
package csp_pkg;

    // clock and timing
    localparam int CLK_MHZ                = 100;
    localparam int POWER_UP_RESET_TIME_US = 45;
    // longest time, rounded down to whole cycles
    localparam int POWER_UP_RESET_CYCLES  =
        POWER_UP_RESET_TIME_US * CLK_MHZ;
    localparam int RST_CNT_W              = 16;

    // geometry
    localparam int NUM_MC      = 8;
    localparam int ARRAY_WORDS = 16;
    localparam int ARRAY_AW    = 4;
    localparam int SIG_BITS    = 64;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_ARR_ADDR  = 8'h08;
    localparam logic [7:0] OFS_ARR_DATA  = 8'h0c;
    localparam logic [7:0] OFS_SIG_LO    = 8'h10;
    localparam logic [7:0] OFS_SIG_HI    = 8'h14;
    localparam logic [7:0] OFS_CYCLES    = 8'h18;
    localparam logic [7:0] OFS_ARCH      = 8'h1c;
    localparam logic [7:0] OFS_MC_STATE  = 8'h20;

    // control bits (write one to act)
    localparam int CTRL_ERASE_BIT = 0;
    localparam int CTRL_LOCK_BIT  = 1;
    localparam int CTRL_CLRERR_BIT = 2;

    // status bits
    localparam int ST_LOCKED_BIT  = 0;
    localparam int ST_PRELOAD_BIT = 1;
    localparam int ST_RSTDONE_BIT = 2;
    localparam int ST_REFUSED_BIT = 3;

    // reset values
    localparam logic [31:0]       RST_WORD   = 32'h0000_0000;
    localparam logic [NUM_MC-1:0] RST_MC     = 8'h00;

endpackage : csp_pkg

// File: hdl/csp_sync.sv
`timescale 1ns/10ps
module csp_sync
    import csp_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         clk_en,
    // async in, synced out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule // csp_sync

// File: hdl/csp_preload_chain.sv
`timescale 1ns/10ps
module csp_preload_chain
    import csp_pkg::*;
(
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              clk_en,
    // control
    input  wire logic              por_clear,
    input  wire logic              preload_active,
    input  wire logic              shift_edge,
    input  wire logic              logic_edge,
    input  wire logic [NUM_MC-1:0] reg_mask,
    // data
    input  wire logic              serial_preload_in,
    input  wire logic [NUM_MC-1:0] next_state,
    output logic      [NUM_MC-1:0] mc_q,
    output logic                   chain_top
);

    logic [NUM_MC-1:0] shift_nxt;

    // registered cells form one chain, lowest index first;
    // unregistered cells are skipped
    always_comb begin
        logic carry;
        carry     = serial_preload_in;
        shift_nxt = mc_q;
        for (int i = 0; i < NUM_MC; i++) begin
            if (reg_mask[i]) begin
                shift_nxt[i] = carry;
                carry        = mc_q[i];
            end
        end
        chain_top = carry;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mc_q <= RST_MC;
        end else if (clk_en) begin
            if (por_clear) begin
                mc_q <= RST_MC;
            end else if (preload_active) begin
                if (shift_edge) begin
                    mc_q <= shift_nxt;
                end
            end else if (logic_edge) begin
                // resumes from whatever was loaded
                mc_q <= (next_state & reg_mask) |
                        (mc_q & ~reg_mask);
            end
        end
    end

endmodule // csp_preload_chain

// File: hdl/csp_top.sv
`timescale 1ns/10ps
module csp_top
    import csp_pkg::*;
#(
    parameter int RESET_CYCLES = POWER_UP_RESET_CYCLES
) (
    // clock, reset, enable
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              clk_en,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // test pins
    input  wire logic              preload_enable_pin,
    input  wire logic              preload_shift_clock,
    input  wire logic              serial_preload_in,
    output logic                   serial_state_out_o,
    output logic                   serial_state_out_oe,
    // logic side
    input  wire logic              logic_clk_pin,
    input  wire logic [NUM_MC-1:0] next_state_in,
    output logic      [NUM_MC-1:0] output_macrocell
);

    // ---------------- pin synchronisers
    logic              pre_s;
    logic              preload_shift_clock_s;
    logic              serial_preload_in_s;
    logic              lclk_s;
    logic [NUM_MC-1:0] nst_s;

    csp_sync #(.W(4 + NUM_MC)) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .clk_en   (clk_en),
        .async_in ({preload_enable_pin, preload_shift_clock,
                    serial_preload_in, logic_clk_pin, next_state_in}),
        .sync_out ({pre_s, preload_shift_clock_s, serial_preload_in_s, lclk_s, nst_s})
    );

    logic preload_shift_clock_d_r;
    logic lclk_d_r;
    logic shift_edge;
    logic logic_edge;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            preload_shift_clock_d_r <= 1'b0;
            lclk_d_r <= 1'b0;
        end else if (clk_en) begin
            preload_shift_clock_d_r <= preload_shift_clock_s;
            lclk_d_r <= lclk_s;
        end
    end

    assign shift_edge = preload_shift_clock_s & ~preload_shift_clock_d_r;
    assign logic_edge = lclk_s & ~lclk_d_r;

    // ---------------- power-up register reset
    logic [RST_CNT_W-1:0] rst_cnt_r;
    logic                 rst_done_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_cnt_r  <= '0;
            rst_done_r <= 1'b0;
        end else if (clk_en && !rst_done_r) begin
            if (rst_cnt_r == RST_CNT_W'(RESET_CYCLES - 1)) begin
                rst_done_r <= 1'b1;
            end else begin
                rst_cnt_r <= rst_cnt_r + RST_CNT_W'(1);
            end
        end
    end

    // ---------------- preload mode
    logic preload_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            preload_r <= 1'b0;
        end else if (clk_en) begin
            // entry needs the reset done; exit on pin drop
            preload_r <= pre_s & rst_done_r;
        end
    end

    // ---------------- nonvolatile state
    logic [31:0]          array_mem [ARRAY_WORDS];
    logic [ARRAY_AW-1:0]  arr_addr_r;
    logic [NUM_MC-1:0]    arch_r;
    logic                 locked_r;
    logic [SIG_BITS-1:0]  sig_r;
    logic [31:0]          cycles_r;
    logic                 refused_r;

    // ---------------- macrocell flops
    logic [NUM_MC-1:0] mc_q;
    logic              chain_top;

    // signature is not wired here on purpose
    csp_preload_chain u_chain (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .clk_en            (clk_en),
        .por_clear         (~rst_done_r),
        .preload_active    (preload_r),
        .shift_edge        (shift_edge),
        .logic_edge        (logic_edge),
        .reg_mask          (arch_r),
        .serial_preload_in (serial_preload_in_s),
        .next_state        (nst_s),
        .mc_q              (mc_q),
        .chain_top         (chain_top)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            output_macrocell    <= '1;
            serial_state_out_o  <= 1'b0;
            serial_state_out_oe <= 1'b0;
        end else if (clk_en) begin
            output_macrocell    <= ~mc_q;
            serial_state_out_o  <= 1'b0;
            // open drain: pull low for a reset bit
            serial_state_out_oe <= preload_r & ~chain_top;
        end
    end

    // ---------------- ahb-lite slave
    logic        dp_wr_r;
    logic [7:0]  dp_addr_r;
    logic        ap_take;

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] v;
        v = RST_WORD;
        unique case (a)
            OFS_STATUS: begin
                v[ST_LOCKED_BIT]  = locked_r;
                v[ST_PRELOAD_BIT] = preload_r;
                v[ST_RSTDONE_BIT] = rst_done_r;
                v[ST_REFUSED_BIT] = refused_r;
            end
            OFS_ARR_ADDR: v[ARRAY_AW-1:0] = arr_addr_r;
            // locked array reads as zero
            OFS_ARR_DATA: v = locked_r ? RST_WORD
                                       : array_mem[arr_addr_r];
            OFS_SIG_LO:   v = sig_r[31:0];
            OFS_SIG_HI:   v = sig_r[63:32];
            OFS_CYCLES:   v = cycles_r;
            OFS_ARCH:     v[NUM_MC-1:0] = locked_r ? RST_MC : arch_r;
            OFS_MC_STATE: v[NUM_MC-1:0] = mc_q;
            default:      v = RST_WORD;
        endcase
        return v;
    endfunction

    assign ap_take = hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= '0;
            hrdata    <= RST_WORD;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            dp_wr_r   <= ap_take & hwrite;
            if (ap_take) begin
                dp_addr_r <= haddr[7:0];
                if (!hwrite) begin
                    hrdata <= rd_mux({haddr[7:2], 2'b00});
                end
            end
        end
    end

    // ---------------- register writes
    logic wr_ctrl;
    logic do_erase;
    logic do_lock;
    logic wr_cfg;

    assign wr_ctrl  = dp_wr_r & (dp_addr_r == OFS_CTRL);
    assign do_erase = wr_ctrl & hwdata[CTRL_ERASE_BIT];
    assign do_lock  = wr_ctrl & hwdata[CTRL_LOCK_BIT] & ~do_erase;
    assign wr_cfg   = dp_wr_r & ((dp_addr_r == OFS_ARR_DATA) |
                                 (dp_addr_r == OFS_ARCH));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arr_addr_r <= '0;
        end else if (clk_en && dp_wr_r && dp_addr_r == OFS_ARR_ADDR) begin
            arr_addr_r <= hwdata[ARRAY_AW-1:0];
        end
    end

    always_ff @(posedge hclk) begin
        if (clk_en) begin
            if (do_erase) begin
                for (int i = 0; i < ARRAY_WORDS; i++) begin
                    array_mem[i] <= RST_WORD;
                end
            end else if (wr_cfg && !locked_r &&
                         dp_addr_r == OFS_ARR_DATA) begin
                array_mem[arr_addr_r] <= hwdata;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arch_r <= RST_MC;
        end else if (clk_en) begin
            if (do_erase) begin
                arch_r <= RST_MC;
            end else if (wr_cfg && !locked_r &&
                         dp_addr_r == OFS_ARCH) begin
                arch_r <= hwdata[NUM_MC-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            locked_r <= 1'b0;
        end else if (clk_en) begin
            if (do_erase) begin
                locked_r <= 1'b0;
            end else if (do_lock) begin
                locked_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sig_r <= '0;
        end else if (clk_en) begin
            if (do_erase) begin
                sig_r <= '0;
            end else if (dp_wr_r && dp_addr_r == OFS_SIG_LO) begin
                sig_r[31:0] <= hwdata;
            end else if (dp_wr_r && dp_addr_r == OFS_SIG_HI) begin
                sig_r[63:32] <= hwdata;
            end
        end
    end

    // one erase starts one programming cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cycles_r <= RST_WORD;
        end else if (clk_en && do_erase) begin
            cycles_r <= cycles_r + 32'h0000_0001;
        end
    end

    // sticky refusal flag, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            refused_r <= 1'b0;
        end else if (clk_en) begin
            if (wr_cfg && locked_r) begin
                refused_r <= 1'b1;
            end else if (wr_ctrl && hwdata[CTRL_CLRERR_BIT]) begin
                refused_r <= 1'b0;
            end
        end
    end

endmodule // csp_top

// File: tb/csp_chk.sv
`timescale 1ns/10ps
module csp_chk
    import csp_pkg::*;
#(
    parameter int RESET_CYCLES = 20
) (
    // clock and reset
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              clk_en,
    // bus
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic              hreadyout,
    input wire logic              hresp,
    // pins
    input wire logic              preload_enable_pin,
    input wire logic              preload_shift_clock,
    input wire logic              logic_clk_pin,
    input wire logic [NUM_MC-1:0] next_state_in,
    input wire logic              serial_state_out_o,
    input wire logic              serial_state_out_oe,
    input wire logic [NUM_MC-1:0] output_macrocell
);
    logic [15:0] pu_cnt_r;
    logic        sig_wr;
    logic        quiet;

    assign sig_wr = hsel && hready && htrans[1] && hwrite
                    && haddr[7:3] == 5'h02;
    assign quiet = !logic_clk_pin && !preload_shift_clock;

    // enabled cycles since reset release, saturating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pu_cnt_r <= 16'h0000;
        end else if (clk_en && pu_cnt_r < 16'(RESET_CYCLES)) begin
            pu_cnt_r <= pu_cnt_r + 16'h0001;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_rst_release;
        $rose(hresetn) |-> output_macrocell == 8'hff && !hreadyout;
    endproperty
    property p_power_up_hold;
        pu_cnt_r < 16'(RESET_CYCLES) |-> output_macrocell == 8'hff;
    endproperty
    property p_oe_idle;
        !preload_enable_pin [*6] |-> !serial_state_out_oe;
    endproperty
    property p_serial_state_out_low;
        serial_state_out_o == 1'b0;
    endproperty
    property p_mc_stable;
        (quiet && $stable(next_state_in)) [*8] |=> $stable(output_macrocell);
    endproperty
    property p_ready;
        $past(hreadyout) |-> hreadyout;
    endproperty
    property p_resp_okay;
        hreadyout |-> !hresp;
    endproperty
    property p_sig_no_effect;
        sig_wr && quiet |=> $stable(output_macrocell) [*4];
    endproperty

    a_rst_release: assert property (p_rst_release)
        else $error("outputs wrong at reset release");
    a_power_up_hold: assert property (p_power_up_hold)
        else $error("macrocell left reset during power-up window");
    a_oe_idle: assert property (p_oe_idle)
        else $error("serial output driven outside preload");
    a_serial_state_out_low: assert property (p_serial_state_out_low)
        else $error("serial output drives high");
    a_mc_stable: assert property (p_mc_stable)
        else $error("macrocell state changed without a clock");
    a_ready: assert property (p_ready)
        else $error("bus stalled");
    a_resp_okay: assert property (p_resp_okay)
        else $error("bus error response");
    a_sig_no_effect: assert property (p_sig_no_effect)
        else $error("signature write disturbed macrocells");

    c_shift_out: cover property ($rose(serial_state_out_oe));
    c_mc_change: cover property ($changed(output_macrocell));
    c_sig_write: cover property (sig_wr);
endmodule // csp_chk

bind csp_top csp_chk #(.RESET_CYCLES(RESET_CYCLES)) csp_chk_i (.*);

// File: tb/csp_tester.sv
`timescale 1ns/10ps
module csp_tester (
    // tester drive
    output logic preload_enable_pin,
    output logic preload_shift_clock,
    output logic serial_preload_in,
    output logic logic_clk_pin,
    // open-drain return, pulled up
    input wire logic serial_state_out_pin
);
    initial begin
        preload_enable_pin = 1'b0;
        preload_shift_clock = 1'b0;
        serial_preload_in = 1'b0;
        logic_clk_pin = 1'b0;
    end

    // called only once power-up reset is over
    task automatic enter();
        #3.1;
        preload_enable_pin = 1'b1;
        #400;
    endtask

    task automatic leave();
        #3.1;
        preload_enable_pin = 1'b0;
        #400;
    endtask

    // bit set up half a period ahead, out bit taken before the rise
    task automatic shift(input logic b, output logic o);
        #3.1;
        serial_preload_in = b;
        #62.5;
        o = serial_state_out_pin;
        preload_shift_clock = 1'b1;
        #62.5;
        preload_shift_clock = 1'b0;
        serial_preload_in = ~b;
    endtask

    task automatic tick();
        #3.1;
        logic_clk_pin = 1'b1;
        #62.5;
        logic_clk_pin = 1'b0;
        #62.5;
    endtask
endmodule // csp_tester

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    import csp_pkg::*;
    localparam int RST_CYC = 20;
    localparam int LIMIT   = 5000;
    localparam logic [4:0] P1 = 5'b01101;
    localparam logic [4:0] P2 = 5'b10010;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, clk_en;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, d, c0;
    logic        preload_enable_pin, preload_shift_clock;
    logic        serial_preload_in, logic_clk_pin, o;
    logic        serial_state_out_o, serial_state_out_oe, serial_state_out_pin;
    logic [7:0]  next_state_in, output_macrocell;
    int          errors = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    assign serial_state_out_pin = serial_state_out_oe ? serial_state_out_o : 1'b1;

    csp_top #(.RESET_CYCLES(RST_CYC)) csp_top_i (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .preload_enable_pin(preload_enable_pin),
        .preload_shift_clock(preload_shift_clock),
        .serial_preload_in(serial_preload_in),
        .serial_state_out_o(serial_state_out_o),
        .serial_state_out_oe(serial_state_out_oe),
        .logic_clk_pin(logic_clk_pin), .next_state_in(next_state_in),
        .output_macrocell(output_macrocell)
    );

    csp_tester csp_tester_i (
        .preload_enable_pin(preload_enable_pin),
        .preload_shift_clock(preload_shift_clock),
        .serial_preload_in(serial_preload_in),
        .logic_clk_pin(logic_clk_pin), .serial_state_out_pin(serial_state_out_pin)
    );

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            errors++;
            final_report();
        end
    end

    task automatic chk_word(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %b seen %b", n, e, g);
        end
    endtask

    task automatic wait_rdy();
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask

    task automatic addr_ph(input logic [7:0] a, input logic w);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        addr_ph(a, 1'b1);
        hwdata <= v;
        wait_rdy();
        @(posedge hclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        addr_ph(a, 1'b0);
        wait_rdy();
        v = hrdata;
    endtask

    // registered cells are 1, 2, 4, 5 and 7
    task automatic mc_chk(input logic [7:0] e);
        logic [31:0] v;
        repeat (6) @(posedge hclk);
        rd(OFS_MC_STATE, v);
        chk_word("mc state", {24'h0, e & 8'hb6}, v & 32'hb6);
        chk_word("pins", {24'h0, ~e & 8'hb6},
                 {24'h0, output_macrocell & 8'hb6});
    endtask

    initial begin
        hresetn = 1'b0;
        clk_en = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'b010;
        haddr = 32'h0;
        hwdata = 32'h0;
        next_state_in = 8'h00;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (RST_CYC + 8) @(posedge hclk);
        rd(OFS_CYCLES, c0);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_CYCLES, d);
        chk_word("cycles", c0 + 32'h1, d);
        rd(OFS_STATUS, d);
        chk_word("status", 32'h4, d);
        wr(OFS_ARR_ADDR, 32'h3);
        wr(OFS_ARR_DATA, 32'ha5c3);
        wr(OFS_SIG_LO, 32'h1234_5678);
        wr(OFS_SIG_HI, 32'h9abc_def0);
        rd(OFS_ARR_DATA, d);
        chk_word("array", 32'ha5c3, d);
        wr(OFS_CTRL, 32'h2);
        rd(OFS_ARR_DATA, d);
        chk_word("array", 32'h0, d);
        wr(OFS_ARR_DATA, 32'h1);
        rd(OFS_STATUS, d);
        chk_word("status", 32'hd, d);
        wr(OFS_CTRL, 32'h4);
        rd(OFS_STATUS, d);
        chk_word("status", 32'h5, d);
        rd(OFS_SIG_LO, d);
        chk_word("sig lo", 32'h1234_5678, d);
        wr(OFS_SIG_HI, 32'h0ff0_1234);
        rd(OFS_SIG_HI, d);
        chk_word("sig hi", 32'h0ff0_1234, d);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_STATUS, d);
        chk_word("status", 32'h4, d);
        rd(OFS_ARR_DATA, d);
        chk_word("array", 32'h0, d);
        rd(OFS_SIG_HI, d);
        chk_word("sig hi", 32'h0, d);
        rd(OFS_ARCH, d);
        chk_word("arch", 32'h0, d);
        rd(OFS_CYCLES, d);
        chk_word("cycles", c0 + 32'h2, d);
        wr(8'h3c, 32'hffff_ffff);
        rd(8'h3c, d);
        chk_word("unmapped", 32'h0, d);
        $display("test bus done");
        wr(OFS_ARCH, 32'hb6);
        csp_tester_i.enter();
        rd(OFS_STATUS, d);
        chk_word("status", 32'h6, d);
        for (int i = 0; i < 5; i++) begin
            csp_tester_i.shift(P1[i], o);
            chk_bit("serial out", 1'b0, o);
        end
        mc_chk(8'h94);
        for (int i = 0; i < 5; i++) begin
            csp_tester_i.shift(P2[i], o);
            chk_bit("serial out", P1[i], o);
        end
        mc_chk(8'h22);
        next_state_in <= 8'h5a;
        csp_tester_i.tick();
        mc_chk(8'h22);
        csp_tester_i.leave();
        rd(OFS_STATUS, d);
        chk_word("status", 32'h4, d);
        csp_tester_i.tick();
        mc_chk(8'h5a);
        // frozen clock enable: the logic clock pulse must be missed
        clk_en <= 1'b0;
        next_state_in <= 8'hff;
        csp_tester_i.tick();
        @(posedge hclk);
        clk_en <= 1'b1;
        mc_chk(8'h5a);
        $display("test preload done");
        final_report();
    end
endmodule // testbench
